/* File: otsup_pkg.sv */
// Purpose: shared constants and types of the overcurrent and thermal supervisor
// Assumes: 50 MHz system clock, 8-bit ratiometric level codes where 255 equals the supply
// Notes:   counts derived from times round as the safety direction demands
package otsup_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned TD1_NS = 1_360_000;
	// least time, rounded up
	localparam int unsigned TD1_CYC = (TD1_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SHUT_NS = 20;
	// longest time, rounded down, never below one cycle
	localparam int unsigned SHUT_CYC = (SHUT_NS / CLK_NS) < 1 ? 1 : (SHUT_NS / CLK_NS);
	localparam int unsigned SW_DIV_CYC = 100;
	localparam int unsigned HICCUP_SW_CYC = 4096;
	localparam int unsigned OC_CONSEC = 8;
	localparam int unsigned CNT_W = 20;
	localparam int unsigned HIC_W = 16;
	localparam int unsigned DIV_W = 16;

	// ----------------------------------------------------------------
	// datapath geometry
	// ----------------------------------------------------------------
	localparam int unsigned PHASE_COUNT = 4;
	localparam int unsigned CURRENT_W = 10;
	localparam int unsigned LEVEL_W = 8;
	localparam int unsigned TEMP_W = 6;
	localparam int unsigned FACTOR_W = 4;
	localparam int unsigned GAIN_W = 11;
	localparam int unsigned GAIN_FRAC = 10;
	localparam int unsigned GAIN_ONE = 1024;
	localparam int unsigned TC_STEP = 4;
	localparam int unsigned TEMP_REF_CODE = 25;
	localparam int unsigned COMP_NEUTRAL = 4;

	// ----------------------------------------------------------------
	// ratiometric thresholds
	// ----------------------------------------------------------------
	localparam int unsigned LEVEL_FULL = 255;
	localparam int unsigned PCT_FULL = 100;
	localparam int unsigned FAN_REL_PCT = 33;
	localparam int unsigned FAN_SET_PCT = 39;
	localparam int unsigned HOT_REL_PCT = 28;
	localparam int unsigned HOT_SET_PCT = 33;
	localparam int unsigned COMP_EN_DIV = 15;
	// release codes round up, so every level truly below the percentage releases
	localparam logic [7:0] FAN_REL_CODE = 8'((LEVEL_FULL * FAN_REL_PCT + PCT_FULL - 1) / PCT_FULL);
	localparam logic [7:0] FAN_SET_CODE = 8'(LEVEL_FULL * FAN_SET_PCT / PCT_FULL);
	localparam logic [7:0] HOT_REL_CODE = 8'((LEVEL_FULL * HOT_REL_PCT + PCT_FULL - 1) / PCT_FULL);
	localparam logic [7:0] HOT_SET_CODE = 8'(LEVEL_FULL * HOT_SET_PCT / PCT_FULL);
	localparam logic [7:0] COMP_STEP = 8'(LEVEL_FULL / COMP_EN_DIV);

	// ----------------------------------------------------------------
	// register map (byte addresses) and reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_OC_REF = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_TEMP = 5'h0C;
	localparam logic [4:0] REG_TRIPS = 5'h10;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [9:0] OC_REF_RST = 10'h200;
	localparam int unsigned ST_FAN_BIT = 2;
	localparam int unsigned ST_HOT_BIT = 3;
	localparam int unsigned ST_COMP_BIT = 4;
	localparam int unsigned ST_EN_BIT = 5;
	localparam int unsigned TEMP_FACTOR_LSB = 8;
	localparam int unsigned TEMP_GAIN_LSB = 16;

	// ----------------------------------------------------------------
	// supervisor states, gray along off, delay, run, wait
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OTSUP_OFF = 2'b00,
		OTSUP_DELAY = 2'b01,
		OTSUP_RUN = 2'b11,
		OTSUP_WAIT = 2'b10
	} otsup_state_e;

endpackage : otsup_pkg

/* File: otsup_temp_comp.sv */
// Purpose: temperature code, compensation factor, gain and compensated channel currents
// Assumes: level codes come from a converter running on mclk_i
// Notes:   the gain is registered; the current scaling is combinational for fast trips
`timescale 1ns/1ps
module otsup_temp_comp import otsup_pkg::*; #(
	parameter int unsigned PHASES = PHASE_COUNT,
	parameter int unsigned CUR_W = CURRENT_W
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// sense levels
	input wire logic [LEVEL_W-1:0] temp_sense_level_i,
	input wire logic [LEVEL_W-1:0] comp_setting_level_i,
	input wire logic [PHASES-1:0][CUR_W-1:0] phase_current_i,
	// results
	output logic [TEMP_W-1:0] temp_code_o,
	output logic [FACTOR_W-1:0] comp_factor_o,
	output logic comp_en_o,
	output logic [GAIN_W-1:0] gain_o,
	output logic [PHASES-1:0][CUR_W-1:0] comp_current_o
);

	typedef struct packed {
		logic [TEMP_W-1:0] code;
		logic [FACTOR_W-1:0] factor;
		logic [GAIN_W-1:0] gain;
	} otsup_tc_s;

	otsup_tc_s s_q;
	otsup_tc_s s_d;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// piecewise conversion: eight segments, steep in the middle and shallow at both ends of the sensor level range
	function automatic logic [TEMP_W-1:0] temp_code_f(input logic [LEVEL_W-1:0] lvl);
		logic [4:0] off;
		logic [5:0] base;
		logic [3:0] span;
		logic [8:0] prod;
		off = 5'h1F - lvl[4:0];
		case (lvl[7:5])
			3'h7: begin base = 6'h00; span = 4'h2; end
			3'h6: begin base = 6'h02; span = 4'h4; end
			3'h5: begin base = 6'h06; span = 4'h8; end
			3'h4: begin base = 6'h0E; span = 4'hC; end
			3'h3: begin base = 6'h1A; span = 4'hC; end
			3'h2: begin base = 6'h26; span = 4'hA; end
			3'h1: begin base = 6'h30; span = 4'h8; end
			default: begin base = 6'h38; span = 4'h7; end
		endcase
		prod = 9'(off * span);
		return base + 6'(prod >> 5);
	endfunction : temp_code_f

	// scale one channel current by the gain, saturating at full scale
	function automatic logic [CUR_W-1:0] comp_f(input logic [CUR_W-1:0] cur,
			input logic [GAIN_W-1:0] g);
		logic [CUR_W+GAIN_W-1:0] p;
		logic [CUR_W+GAIN_W-1:0] q;
		p = (CUR_W+GAIN_W)'(cur) * (CUR_W+GAIN_W)'(g);
		q = p >> GAIN_FRAC;
		return (q > (CUR_W+GAIN_W)'({CUR_W{1'b1}})) ? {CUR_W{1'b1}} : q[CUR_W-1:0];
	endfunction : comp_f

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// hotter effective temperature lowers the gain to cancel the sense element's rise
	always_comb begin
		logic signed [12:0] eff;
		logic [12:0] g;
		eff = 13'sh0;
		g = 13'h0;
		s_d = s_q;
		s_d.code = temp_code_f(temp_sense_level_i);
		s_d.factor = 4'(comp_setting_level_i / COMP_STEP);
		eff = $signed(13'(s_q.code)) + $signed(13'(s_q.factor))
			- $signed(13'(COMP_NEUTRAL)) - $signed(13'(TEMP_REF_CODE));
		g = 13'(GAIN_ONE) - 13'(eff) * 13'(TC_STEP);
		if (s_q.factor == 4'h0) begin
			s_d.gain = 11'(GAIN_ONE);
		end else begin
			s_d.gain = g[GAIN_W-1:0];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '{code: '0, factor: '0, gain: 11'(GAIN_ONE)};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// factor zero is exactly a level below one fifteenth of the supply
	assign comp_en_o = (s_q.factor != 4'h0);
	assign temp_code_o = s_q.code;
	assign comp_factor_o = s_q.factor;
	assign gain_o = s_q.gain;

	// every channel is scaled by the same gain
	always_comb begin
		for (int i = 0; i < PHASES; i++) begin
			comp_current_o[i] = comp_f(phase_current_i[i], s_q.gain);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_comp_off_gain: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(comp_setting_level_i < COMP_STEP) |=> ##1 (gain_o == 11'(GAIN_ONE)))
		else $error("zero factor did not force unity gain");
	chk_comp_enable: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(comp_setting_level_i >= COMP_STEP) |=> comp_en_o)
		else $error("compensation not enabled above threshold");

endmodule : otsup_temp_comp

/* File: otsup_top.sv */
// Purpose: hiccup overcurrent supervision, thermal outputs and register access
// Assumes: channel currents and level codes are sampled on mclk_i; enable pins are async
// Notes:   pwm pins are tri-state; the output enable is active low and taken from state
`timescale 1ns/1ps
module otsup_top import otsup_pkg::*; #(
	parameter int unsigned PHASES = PHASE_COUNT,
	parameter int unsigned CUR_W = CURRENT_W,
	parameter int unsigned SW_DIV = SW_DIV_CYC,
	parameter int unsigned TD1_CYCLES = TD1_CYC,
	parameter int unsigned HICCUP_CYCLES = HICCUP_SW_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// enable pins, asynchronous
	input wire logic supply_ok_i,
	input wire logic power_rail_enable_i,
	input wire logic termination_rail_enable_i,
	// sense data on mclk_i
	input wire logic [PHASES-1:0][CUR_W-1:0] phase_current_i,
	input wire logic [LEVEL_W-1:0] temp_sense_level_i,
	input wire logic [LEVEL_W-1:0] comp_setting_level_i,
	// modulator and drivers
	input wire logic [PHASES-1:0] pwm_i,
	output logic [PHASES-1:0] pwm_o,
	output logic [PHASES-1:0] pwm_oe_n_o,
	output logic ramp_start_o,
	output logic [CUR_W+1:0] droop_current_o,
	// open-drain thermal outputs
	output logic fan_request_n_o,
	output logic fan_request_n_oe_n_o,
	output logic over_temp_alarm_n_o,
	output logic over_temp_alarm_n_oe_n_o,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sync3;
		logic [2:0] pin_f;
		logic [DIV_W-1:0] div;
		otsup_state_e state;
		logic [CNT_W-1:0] td_cnt;
		logic [HIC_W-1:0] hic_cnt;
		logic [PHASES-1:0][3:0] oc_cnt;
		logic fan_rel;
		logic hot_rel;
		logic ctrl_en;
		logic [CUR_W-1:0] oc_ref;
		logic [15:0] trips;
		logic ack;
		logic [31:0] rdata;
		logic ramp;
		logic [CUR_W+1:0] droop;
		logic [PHASES-1:0] pwm;
	} otsup_top_s;

	otsup_top_s s_q;
	otsup_top_s s_d;

	logic [TEMP_W-1:0] temp_code;
	logic [FACTOR_W-1:0] comp_factor;
	logic comp_en;
	logic [GAIN_W-1:0] gain;
	logic [PHASES-1:0][CUR_W-1:0] comp_cur;
	logic [CUR_W+1:0] cur_sum;
	logic [CUR_W+1:0] cur_avg;
	logic avg_over;
	logic [PHASES-1:0] ph_over;
	logic tick;
	logic enabled;
	logic phase_trip;
	logic access;

	// ----------------------------------------------------------------
	// compensation datapath
	// ----------------------------------------------------------------
	otsup_temp_comp #(.PHASES(PHASES), .CUR_W(CUR_W)) u_comp (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.temp_sense_level_i(temp_sense_level_i),
		.comp_setting_level_i(comp_setting_level_i),
		.phase_current_i(phase_current_i),
		.temp_code_o(temp_code),
		.comp_factor_o(comp_factor),
		.comp_en_o(comp_en),
		.gain_o(gain),
		.comp_current_o(comp_cur)
	);

	// compensated currents feed both the trip compares and the droop output
	always_comb begin
		cur_sum = '0;
		for (int i = 0; i < PHASES; i++) begin
			cur_sum = cur_sum + (CUR_W+2)'(comp_cur[i]);
			ph_over[i] = (comp_cur[i] > s_q.oc_ref);
		end
		cur_avg = cur_sum / (CUR_W+2)'(PHASES);
		avg_over = (cur_avg > (CUR_W+2)'(s_q.oc_ref));
	end

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	assign tick = (s_q.div == DIV_W'(SW_DIV - 1));
	assign enabled = (&s_q.pin_f) & s_q.ctrl_en;
	assign access = avs_read_i | avs_write_i;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		phase_trip = 1'b0;
		// three stage pin sync; a level counts once stages two and three agree
		s_d.sync1 = {supply_ok_i, power_rail_enable_i, termination_rail_enable_i};
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		for (int i = 0; i < 3; i++) begin
			if (s_q.sync2[i] == s_q.sync3[i]) begin
				s_d.pin_f[i] = s_q.sync3[i];
			end
		end
		// switching-cycle enable from a free divider
		s_d.div = tick ? '0 : s_q.div + 1'b1;
		s_d.ramp = 1'b0;
		s_d.pwm = pwm_i;
		s_d.droop = cur_sum;

		// per-phase consecutive counters, live only while running
		for (int i = 0; i < PHASES; i++) begin
			if (s_q.state != OTSUP_RUN) begin
				s_d.oc_cnt[i] = 4'h0;
			end else if (tick) begin
				if (ph_over[i]) begin
					s_d.oc_cnt[i] = s_q.oc_cnt[i] + 4'h1;
					if (s_q.oc_cnt[i] == 4'(OC_CONSEC - 1)) begin
						phase_trip = 1'b1;
					end
				end else begin
					s_d.oc_cnt[i] = 4'h0;
				end
			end
		end

		// hiccup sequence
		case (s_q.state)
			OTSUP_OFF: begin
				if (enabled) begin
					s_d.state = OTSUP_DELAY;
					s_d.td_cnt = '0;
				end
			end
			OTSUP_DELAY: begin
				if (!enabled) begin
					s_d.state = OTSUP_OFF;
				end else if (s_q.td_cnt == CNT_W'(TD1_CYCLES - 1)) begin
					s_d.state = OTSUP_RUN;
					s_d.ramp = 1'b1;
				end else begin
					s_d.td_cnt = s_q.td_cnt + 1'b1;
				end
			end
			OTSUP_RUN: begin
				if (!enabled) begin
					s_d.state = OTSUP_OFF;
				end else if (avg_over || phase_trip) begin
					s_d.state = OTSUP_WAIT;
					s_d.hic_cnt = '0;
					s_d.oc_cnt = '0;
					if (s_q.trips != 16'hFFFF) begin
						s_d.trips = s_q.trips + 16'h1;
					end
				end
			end
			OTSUP_WAIT: begin
				if (!enabled) begin
					s_d.state = OTSUP_OFF;
					s_d.hic_cnt = '0;
					s_d.oc_cnt = '0;
				end else if (tick) begin
					if (s_q.hic_cnt == HIC_W'(HICCUP_CYCLES - 1)) begin
						s_d.state = OTSUP_DELAY;
						s_d.td_cnt = '0;
					end else begin
						s_d.hic_cnt = s_q.hic_cnt + 1'b1;
					end
				end
			end
			default: begin
				s_d.state = OTSUP_OFF;
			end
		endcase

		// thermal comparators with hysteresis; released means driver off
		if (temp_sense_level_i < FAN_REL_CODE) begin
			s_d.fan_rel = 1'b1;
		end else if (temp_sense_level_i > FAN_SET_CODE) begin
			s_d.fan_rel = 1'b0;
		end
		if (temp_sense_level_i < HOT_REL_CODE) begin
			s_d.hot_rel = 1'b1;
		end else if (temp_sense_level_i > HOT_SET_CODE) begin
			s_d.hot_rel = 1'b0;
		end

		// bus: one wait cycle per access, then the answer stands for the release edge
		s_d.ack = access & ~s_q.ack;
		if (access && !s_q.ack) begin
			case (avs_address_i)
				REG_CTRL: s_d.rdata = {31'h0, s_q.ctrl_en};
				REG_OC_REF: s_d.rdata = 32'(s_q.oc_ref);
				REG_STATUS: s_d.rdata = 32'({enabled, comp_en, s_q.hot_rel, s_q.fan_rel,
					s_q.state});
				REG_TEMP: s_d.rdata = (32'(gain) << TEMP_GAIN_LSB)
					| (32'(comp_factor) << TEMP_FACTOR_LSB) | 32'(temp_code);
				REG_TRIPS: s_d.rdata = 32'(s_q.trips);
				default: s_d.rdata = 32'h0;
			endcase
		end
		if (avs_write_i && s_q.ack) begin
			if (avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
				s_d.ctrl_en = avs_writedata_i[0];
			end
			if (avs_address_i == REG_OC_REF) begin
				for (int b = 0; b < CUR_W; b++) begin
					if (avs_byteenable_i[b/8]) begin
						s_d.oc_ref[b] = avs_writedata_i[b];
					end
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '{state: OTSUP_OFF, ctrl_en: CTRL_EN_RST,
				oc_ref: CUR_W'(OC_REF_RST), default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// float from the very edge that enters wait; the drivers then turn both switches off
	assign pwm_oe_n_o = {PHASES{s_q.state != OTSUP_RUN}};
	assign pwm_o = s_q.pwm;
	assign ramp_start_o = s_q.ramp;
	assign droop_current_o = s_q.droop;
	// open drain: data is always low, enable low only when pulling
	assign fan_request_n_o = 1'b0;
	assign fan_request_n_oe_n_o = s_q.fan_rel;
	assign over_temp_alarm_n_o = 1'b0;
	assign over_temp_alarm_n_oe_n_o = s_q.hot_rel;
	assign avs_readdata_o = s_q.rdata;
	assign avs_waitrequest_o = access & ~s_q.ack;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_avg_trip_now: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(s_q.state == OTSUP_RUN && enabled && avg_over) |=> (s_q.state == OTSUP_WAIT))
		else $error("average overcurrent did not trip");
	chk_phase_trip_eight: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(s_q.state == OTSUP_RUN && enabled && tick && ph_over[0] && s_q.oc_cnt[0] == 4'h7)
		|=> (s_q.state == OTSUP_WAIT))
		else $error("eighth over cycle did not trip");
	chk_shut_float: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(s_q.state == OTSUP_RUN && enabled && avg_over) |=> (&pwm_oe_n_o))
		else $error("pwm not floated one cycle after trip");
	chk_wait_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(s_q.state == OTSUP_WAIT && enabled && !(tick && s_q.hic_cnt == HIC_W'(HICCUP_CYCLES - 1)))
		|=> (s_q.state == OTSUP_WAIT))
		else $error("wait left early");
	chk_retry_start: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(s_q.state == OTSUP_WAIT && enabled && tick && s_q.hic_cnt == HIC_W'(HICCUP_CYCLES - 1))
		|=> (s_q.state == OTSUP_DELAY && s_q.td_cnt == '0))
		else $error("retry did not start soft-start delay");
	chk_float_idle: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!enabled) |=> (&pwm_oe_n_o))
		else $error("pwm driven while disabled");
	chk_delay_ramp: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$rose(ramp_start_o) |-> (s_q.state == OTSUP_RUN && $past(s_q.state) == OTSUP_DELAY))
		else $error("ramp started without the fixed delay");
	chk_count_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(tick && !ph_over[0]) |=> (s_q.oc_cnt[0] == 4'h0))
		else $error("phase counter not cleared");
	chk_wait_abort: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(s_q.state == OTSUP_WAIT && !enabled) |=> (s_q.state == OTSUP_OFF && s_q.hic_cnt == '0))
		else $error("disable in wait did not abort");
	chk_fan_release: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(temp_sense_level_i < FAN_REL_CODE) |=> fan_request_n_oe_n_o)
		else $error("fan output not released");
	chk_hot_pull: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(temp_sense_level_i > HOT_SET_CODE) |=> !over_temp_alarm_n_oe_n_o)
		else $error("alarm output not pulled low");

endmodule : otsup_top

/* File: otsup_pin_model.sv */
// Purpose: driver ics and thermal monitor as seen at the pins
// Assumes: pull-ups on both thermal lines
// Notes: a floated pwm input makes the driver hold both fets off
`timescale 1ns/1ps
module otsup_pin_model (
	// from the supervisor
	input wire logic [3:0] pwm_oe_n_i,
	input wire logic fan_i,
	input wire logic fan_oe_n_i,
	input wire logic hot_i,
	input wire logic hot_oe_n_i,
	// pin levels
	output logic [3:0] fets_off_o,
	output logic fan_pin_o,
	output logic hot_pin_o
);
	// a released line goes to the pull-up, never to the last level
	assign fan_pin_o = fan_oe_n_i ? 1'b1 : fan_i;
	assign hot_pin_o = hot_oe_n_i ? 1'b1 : hot_i;
	// high-z input turns both fets off
	assign fets_off_o = pwm_oe_n_i;
endmodule : otsup_pin_model

/* File: tb.sv */
// Purpose: self-checking bench of the supervisor
// Assumes: short hiccup, delay and switching counts
// Notes: hiccup timing is checked in a window, ticks are free running
`timescale 1ns/1ps
module tb import otsup_pkg::*;;
	localparam int TD1 = 20;
	localparam int HIC = 4;
	localparam int SW = 4;
	logic mclk, rst_n, sup_ok, rail_en, term_en, wr, rd, wreq, ramp;
	logic [3:0][9:0] cur;
	logic [7:0] tlev, clev;
	logic [3:0] pwm, pwm_q, pwm_p, oe_n, fets_off, be;
	logic [11:0] droop;
	logic [4:0] adr;
	logic [31:0] wdat, rdat, r;
	logic fan, fan_oe_n, hot, hot_oe_n, fan_pin, hot_pin;
	int error_cnt, num_checks, n, i, fan_m, hot_m, g_prev;
	int lv[5] = '{0, 16, 17, 68, 255};
	otsup_top #(.SW_DIV(SW), .TD1_CYCLES(TD1), .HICCUP_CYCLES(HIC)) dut_u (
		.mclk_i(mclk), .resetn_i(rst_n), .supply_ok_i(sup_ok),
		.power_rail_enable_i(rail_en), .termination_rail_enable_i(term_en),
		.phase_current_i(cur), .temp_sense_level_i(tlev), .comp_setting_level_i(clev),
		.pwm_i(pwm), .pwm_o(pwm_q), .pwm_oe_n_o(oe_n), .ramp_start_o(ramp),
		.droop_current_o(droop),
		.fan_request_n_o(fan), .fan_request_n_oe_n_o(fan_oe_n),
		.over_temp_alarm_n_o(hot), .over_temp_alarm_n_oe_n_o(hot_oe_n),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
	otsup_pin_model pins_u (.pwm_oe_n_i(oe_n), .fan_i(fan), .fan_oe_n_i(fan_oe_n),
		.hot_i(hot), .hot_oe_n_i(hot_oe_n), .fets_off_o(fets_off),
		.fan_pin_o(fan_pin), .hot_pin_o(hot_pin));
	// ----------------------------------------------------------------
	// clock, random modulator and shared tasks
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// pwm_p keeps the level that the supervisor sampled at the last edge
	always @(posedge mclk) begin
		pwm <= 4'($urandom);
		pwm_p <= pwm;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one avalon cycle; request held until the edge that samples waitrequest low
	task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		adr <= a;
		wdat <= d;
		wr <= we;
		rd <= !we;
		for (k = 0; k < 50; k++) begin
			@(posedge mclk);
			if (wreq === 1'b0) break;
		end
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (k == 50) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : bus
	// bounded waits for the ramp pulse and for the float
	task automatic wramp(output int c);
		for (c = 1; c < 500; c++) begin
			@(negedge mclk);
			if (ramp === 1'b1) break;
		end
		if (c == 500) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : wramp
	task automatic wfloat(input int lim, output int c);
		for (c = 0; c < lim && oe_n !== 4'hF; c++) @(negedge mclk);
		if (oe_n !== 4'hF) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : wfloat
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h1cce));
		{rst_n, wr, rd, sup_ok, rail_en, term_en} = '0;
		adr = '0;
		wdat = '0;
		be = 4'hF;
		cur = {4{10'h100}};
		tlev = 8'h80;
		clev = '0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		bus(1'b0, REG_OC_REF, '0);
		chk(r, 32'h200);
		bus(1'b0, 5'h14, '0);
		chk(r, 32'h0);
		// reference write, then a low-byte-only write keeps bits 9:8
		n = $urandom_range(0, 1023);
		bus(1'b1, REG_OC_REF, 32'(n));
		be <= 4'h1;
		bus(1'b1, REG_OC_REF, 32'h0);
		bus(1'b0, REG_OC_REF, '0);
		chk(r, 32'(n) & 32'h300);
		be <= 4'hF;
		bus(1'b1, REG_OC_REF, 32'h200);
		// factor table, with the enable threshold on both sides
		for (i = 0; i < 5; i++) begin
			@(posedge mclk) clev <= 8'(lv[i]);
			repeat (3) @(posedge mclk);
			bus(1'b0, REG_TEMP, '0);
			chk(r[11:8], lv[i] / 17);
			if (lv[i] == 0) chk(r[26:16], GAIN_ONE);
			if (lv[i] < 17) chk(droop, 4 * 10'h100);
			if (i > 2) chk(r[26:16] < g_prev, 1);
			if (i == 4) chk(droop < 4 * 10'h100, 1);
			g_prev = r[26:16];
			bus(1'b0, REG_STATUS, '0);
			chk(r[4], lv[i] >= 17);
		end
		@(posedge mclk) clev <= '0;
		$display("compensation test done");
		// thermal hysteresis against an integer model
		repeat (30) begin
			@(posedge mclk) tlev <= 8'($urandom_range(40, 120));
			repeat (3) @(posedge mclk);
			if (tlev < FAN_REL_CODE) fan_m = 1;
			else if (tlev > FAN_SET_CODE) fan_m = 0;
			if (tlev < HOT_REL_CODE) hot_m = 1;
			else if (tlev > HOT_SET_CODE) hot_m = 0;
			@(negedge mclk);
			chk(fan_pin, fan_m);
			chk(hot_pin, hot_m);
			chk(oe_n, 4'hF);
			chk(pwm_q, pwm_p);
		end
		// a lower sense level means hotter, so a larger code
		@(posedge mclk) tlev <= 8'h30;
		repeat (2) @(posedge mclk);
		bus(1'b0, REG_TEMP, '0);
		n = r[5:0];
		@(posedge mclk) tlev <= 8'hC0;
		repeat (2) @(posedge mclk);
		bus(1'b0, REG_TEMP, '0);
		chk(n > r[5:0], 1);
		$display("thermal test done");
		// averaged overcurrent held: trip, wait, retry, trip again
		@(posedge mclk) cur <= {4{10'h3FF}};
		{sup_ok, rail_en, term_en} <= 3'b111;
		wramp(n);
		chk(oe_n, 4'h0);
		chk(droop, 4 * 10'h3FF);
		for (i = 0; i < 3; i++) begin
			wfloat(4, n);
			chk(oe_n, 4'hF);
			chk(fets_off, 4'hF);
			if (i < 2) begin
				wramp(n);
				chk(n >= (HIC - 1) * SW + TD1 + 1 && n <= HIC * SW + TD1, 1);
				chk(oe_n, 4'h0);
			end
		end
		// enable lost in the wait
		@(posedge mclk) rail_en <= 1'b0;
		repeat (6) @(posedge mclk);
		bus(1'b0, REG_STATUS, '0);
		chk(r[1:0], 2'b00);
		chk(oe_n, 4'hF);
		$display("hiccup test done");
		// one phase over, average below the reference
		@(posedge mclk) cur <= 40'h3FF;
		rail_en <= 1'b1;
		wramp(n);
		wfloat(60, n);
		chk(n >= 7 * SW + 1 && n <= 8 * SW, 1);
		bus(1'b1, REG_TRIPS, 32'h0);
		bus(1'b0, REG_TRIPS, '0);
		chk(r, 32'h4);
		// software disable inside the wait aborts the retry
		bus(1'b1, REG_CTRL, 32'h0);
		bus(1'b0, REG_STATUS, '0);
		chk(r[1:0], 2'b00);
		chk(r[5], 1'b0);
		chk(oe_n, 4'hF);
		$display("phase test done");
		report_and_stop();
	end
endmodule : tb
